// file: dac_refresh_sequencer.sv
`timescale 1ns/10ps
`include "dac_seq_defs.svh"

// level synchroniser for the pins and the word toggle that reach core_clk from outside
module pin_sync #(
   parameter int STAGES = 2
) (
   input wire logic clk,
   input wire logic d,
   output logic q
);
   logic [STAGES-1:0] ff_reg;

   // only the last stage is read, so metastability stays in the chain
   always_ff @(posedge clk) begin
      ff_reg <= {ff_reg[STAGES-2:0], d};
   end

   assign q = ff_reg[STAGES-1];
endmodule : pin_sync

module dac_refresh_sequencer (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic serial_clk,
   input wire logic cs_n,
   input wire logic serial_din,
   input wire logic reset_pin_n,
   input wire logic immediate_select_pin,
   input wire logic ext_clock_select_pin,
   input wire logic ext_seq_clock,
   output dac_seq_pkg::conv_s conv,
   output logic clearing,
   output logic ext_clock_active
);
   import dac_seq_pkg::*;

   // ---------------- link domain: serial shift register ----------------
   // cs_n high resets the bit count asynchronously to the link, since the
   // link clock may stop outside frames
   logic [23:0] shift_reg;
   logic [4:0] bit_cnt_reg;
   logic word_tgl_reg;
   logic [23:0] word_hold_reg;
   logic [23:0] shift_next;
   assign shift_next = {shift_reg[22:0], serial_din};

   always_ff @(posedge serial_clk or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt_reg <= 5'h00;
      end else if (bit_cnt_reg == 5'(`WORD_BITS - 1)) begin
         bit_cnt_reg <= 5'h00;
      end else begin
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
   end

   // the 24th rising edge of a frame completes a word
   wire word_last = !cs_n && bit_cnt_reg == 5'(`WORD_BITS - 1);

   always_ff @(posedge serial_clk) begin
      shift_reg <= shift_next;
   end

   always_ff @(posedge serial_clk) begin
      if (word_last) begin
         word_hold_reg <= shift_next;
      end
   end

   // a known start keeps the core from seeing a false word after reset
   always_ff @(posedge serial_clk or posedge reset) begin
      if (reset) begin
         word_tgl_reg <= 1'b0;
      end else if (word_last) begin
         word_tgl_reg <= ~word_tgl_reg;
      end
   end

   // ---------------- core domain synchronisers ----------------
   // every level from a pin, and the word toggle from the link clock, passes two flops; word_hold_reg is read directly
   logic tgl_sync;
   logic cs_sync;
   logic rst_sync;
   logic imm_sync;
   logic sel_sync;
   logic ext_seq_clock_sync;
   logic tgl_last_reg;
   logic ext_seq_clock_last_reg;

   // word toggle from the link domain
   pin_sync #(
      .STAGES(2)
   ) tgl_sync_i (
      .clk(core_clk),
      .d(word_tgl_reg),
      .q(tgl_sync)
   );

   // chip select
   pin_sync #(
      .STAGES(2)
   ) cs_sync_i (
      .clk(core_clk),
      .d(cs_n),
      .q(cs_sync)
   );

   // reset pin
   pin_sync #(
      .STAGES(2)
   ) rst_sync_i (
      .clk(core_clk),
      .d(reset_pin_n),
      .q(rst_sync)
   );

   // immediate select pin
   pin_sync #(
      .STAGES(2)
   ) imm_sync_i (
      .clk(core_clk),
      .d(immediate_select_pin),
      .q(imm_sync)
   );

   // external clock select pin
   pin_sync #(
      .STAGES(2)
   ) sel_sync_i (
      .clk(core_clk),
      .d(ext_clock_select_pin),
      .q(sel_sync)
   );

   // external sequencer clock, slow enough to be sampled
   pin_sync #(
      .STAGES(2)
   ) ext_seq_clock_sync_i (
      .clk(core_clk),
      .d(ext_seq_clock),
      .q(ext_seq_clock_sync)
   );

   always_ff @(posedge core_clk) begin
      if (reset) begin
         tgl_last_reg <= 1'b0;
      end else begin
         tgl_last_reg <= tgl_sync;
      end
   end

   // reset to the idle level of the pin, so no false edge follows reset
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ext_seq_clock_last_reg <= 1'b0;
      end else begin
         ext_seq_clock_last_reg <= ext_seq_clock_sync;
      end
   end

   wire cs_low = ~cs_sync;
   wire rst_low = ~rst_sync;
   // word_hold_reg is stable for many link clocks after the toggle
   wire word_evt = tgl_sync ^ tgl_last_reg;
   wire ext_seq_clock_rise = ext_seq_clock_sync & ~ext_seq_clock_last_reg;

   word_s rx_word;
   assign rx_word.data = word_hold_reg[`F_DATA_HI:`F_DATA_LO];
   assign rx_word.addr = word_hold_reg[`F_ADDR_HI:`F_ADDR_LO];
   assign rx_word.upd = word_hold_reg[`F_UPD];
   assign rx_word.clk = word_hold_reg[`F_CLK];

   // ---------------- state ----------------
   seq_e state_reg;
   logic [15:0] mem_reg [`NUM_CH];
   logic [3:0] scan_addr_reg;
   logic [3:0] resume_addr_reg;
   logic [3:0] imm_addr_reg;
   logic upd_bit_reg;
   logic clk_bit_reg;
   logic imm_pend_reg;
   logic [9:0] slot_cnt_reg;
   logic [1:0] div_cnt_reg;
   logic [2:0] eslot_cnt_reg;
   logic slot_busy_reg;
   conv_s conv_reg;

   // the clearing run always uses the internal slot timer
   wire use_ext = (clk_bit_reg | sel_sync)
      & state_reg != ST_CLEAR;
   wire imm_mode = imm_sync | upd_bit_reg;
   wire word_ok = word_evt & state_reg != ST_CLEAR;

   // quarter-rate tick from the external clock
   wire ext_tick = ext_seq_clock_rise & div_cnt_reg == 2'(`EXT_DIV - 1);
   wire int_end = slot_cnt_reg == 10'(`SLOT_CYCLES - 1);
   wire ext_end = ext_tick & eslot_cnt_reg == 3'(`EXT_SLOT_TICKS - 1);
   // settle point: half way through the slot for either source
   wire int_mid = slot_cnt_reg == 10'(`SETTLE_CYCLES - 1);
   wire slot_end = use_ext ? ext_end : int_end;
   wire slot_mid = use_ext ? ext_tick & eslot_cnt_reg == 3'h0 : int_mid;

   wire in_clear = state_reg == ST_CLEAR;
   wire in_imm = state_reg == ST_IMM;
   wire in_hold = state_reg == ST_HOLD;
   wire clear_last = in_clear && scan_addr_reg == 4'hf;

   // next slot is started only here; a started slot always completes
   // the clearing run ignores the serial port, so a frame cannot stall it
   wire may_start = in_clear
      || (!cs_low && !(word_evt && imm_mode));
   wire start_ok = slot_end && !in_hold && may_start && !rst_low;
   wire [3:0] start_addr = in_imm ? imm_addr_reg : scan_addr_reg;
   wire go_hold = state_reg == ST_SCAN && cs_low;
   wire go_resume = in_hold && !cs_low;
   wire word_take = word_ok && !rst_low;
   wire imm_word = word_take
      && (imm_sync | rx_word.upd);
   wire imm_done = start_ok && in_imm;
   seq_e state_next;
   conv_s conv_next;

   // four external clock rises make one sequencer tick
   always_ff @(posedge core_clk) begin
      if (reset) begin
         div_cnt_reg <= 2'h0;
      end else if (ext_seq_clock_rise) begin
         div_cnt_reg <= div_cnt_reg + 2'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         eslot_cnt_reg <= 3'h0;
      end else if (ext_tick) begin
         eslot_cnt_reg <= ext_end ? 3'h0 : eslot_cnt_reg + 3'h1;
      end
   end

   // free running, so internal slots keep one fixed grid
   always_ff @(posedge core_clk) begin
      if (reset) begin
         slot_cnt_reg <= 10'h000;
      end else begin
         slot_cnt_reg <= int_end ? 10'h000 : slot_cnt_reg + 10'h001;
      end
   end

   // the reset pin outranks a frame, so a held select cannot block it
   always_comb begin
      state_next = state_reg;
      if (rst_low) begin
         state_next = ST_CLEAR;
      end else if (go_hold) begin
         state_next = ST_HOLD;
      end else if (go_resume) begin
         state_next = imm_pend_reg ? ST_IMM : ST_SCAN;
      end else if (start_ok && (in_imm || clear_last)) begin
         state_next = ST_SCAN;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= ST_CLEAR;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset || rst_low) begin
         scan_addr_reg <= 4'h0;
      end else if (go_resume) begin
         scan_addr_reg <= resume_addr_reg;
      end else if (start_ok && !in_imm) begin
         scan_addr_reg <= scan_addr_reg + 4'h1;
      end
   end

   // the pointer has already stepped past a slot in progress, which is
   // allowed to finish, so it is the place to come back to
   always_ff @(posedge core_clk) begin
      if (reset) begin
         resume_addr_reg <= 4'h0;
      end else if (go_hold && !rst_low) begin
         resume_addr_reg <= scan_addr_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         imm_addr_reg <= 4'h0;
      end else if (imm_word) begin
         imm_addr_reg <= rx_word.addr;
      end
   end

   // a new word wins over the slot that retires the old one
   always_ff @(posedge core_clk) begin
      if (reset || rst_low) begin
         imm_pend_reg <= 1'b0;
      end else if (imm_word) begin
         imm_pend_reg <= 1'b1;
      end else if (imm_done) begin
         imm_pend_reg <= 1'b0;
      end
   end

   // control bits last until the next complete word
   always_ff @(posedge core_clk) begin
      if (reset || rst_low) begin
         upd_bit_reg <= 1'b0;
      end else if (word_take) begin
         upd_bit_reg <= rx_word.upd;
      end
   end

   // a host that wants to stay on the external clock repeats this bit
   always_ff @(posedge core_clk) begin
      if (reset || rst_low) begin
         clk_bit_reg <= 1'b0;
      end else if (word_take) begin
         clk_bit_reg <= rx_word.clk;
      end
   end

   always_ff @(posedge core_clk) begin
      if (in_clear) begin
         mem_reg[scan_addr_reg] <= `CLEAR_CODE;
      end else if (word_take) begin
         mem_reg[rx_word.addr] <= rx_word.data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         slot_busy_reg <= 1'b0;
      end else if (start_ok) begin
         slot_busy_reg <= 1'b1;
      end else if (slot_end) begin
         slot_busy_reg <= 1'b0;
      end
   end

   // code and channel stand for the whole slot; load and strobe pulse
   always_comb begin
      conv_next = conv_reg;
      conv_next.load = start_ok;
      conv_next.strobe = slot_mid && slot_busy_reg;
      if (start_ok) begin
         conv_next.channel = start_addr;
         conv_next.code = mem_reg[start_addr];
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         conv_reg <= '0;
      end else begin
         conv_reg <= conv_next;
      end
   end

   assign conv = conv_reg;
   assign clearing = in_clear;
   assign ext_clock_active = use_ext;
endmodule : dac_refresh_sequencer

// file: dac_refresh_sequencer_props.sv
`timescale 1ns/10ps
`include "dac_seq_defs.svh"
module dac_refresh_sequencer_props (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic cs_n,
   input wire logic reset_pin_n,
   input wire logic ext_clock_select_pin,
   input wire dac_seq_pkg::conv_s conv,
   input wire logic clearing,
   input wire logic ext_clock_active
);
   import dac_seq_pkg::*;
   logic [9:0] cs_cnt_reg;
   logic [10:0] gap_reg;
   logic [3:0] ch_reg;
   logic clr_reg;
   logic [9:0] age_reg;
   // saturating, so a long frame cannot wrap back into the grace window
   always_ff @(posedge core_clk) begin
      cs_cnt_reg <= (reset || cs_n) ? '0 : cs_cnt_reg + {9'h000, ~&cs_cnt_reg};
      gap_reg <= conv.load ? 11'h001 : gap_reg + 11'h001;
      if (conv.load) ch_reg <= conv.channel;
      clr_reg <= !reset && (conv.load ? clearing : clr_reg);
      if (reset || ext_clock_active) age_reg <= 10'h000;
      else if (conv.load) age_reg <= 10'h001;
      else if (age_reg != 10'h000) age_reg <= age_reg + 10'h001;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   // counted from an internal load; a change of source ends the count
   sequence s_int_settled;
      age_reg == 10'h190 && !ext_clock_active;
   endsequence
   a_slot_settle:
      assert property (s_int_settled |-> conv.strobe)
      else $error("no strobe at settle point");
   a_cs_quiet:
      assert property (cs_cnt_reg > 10'h32a && !ext_clock_active && !clearing
         |-> !conv.load && !conv.strobe) else $error("refresh while selected");
   a_pin_ext:
      assert property (ext_clock_select_pin && !clearing
         |-> ##[0:3] (ext_clock_active || clearing)) else $error("pin ignored");
   a_clear_internal:
      assert property (clearing |-> !ext_clock_active)
      else $error("external clock in clearing");
   a_clear_code:
      assert property (clearing && conv.load |-> conv.code == `CLEAR_CODE)
      else $error("wrong clear code");
   a_clear_order:
      assert property (clearing && conv.load && clr_reg
         |-> conv.channel == ch_reg + 4'h1 && gap_reg == `SLOT_CYCLES)
      else $error("clear slot order or length");
   a_pin_clear:
      assert property ($fell(reset_pin_n) |-> ##[1:4] clearing)
      else $error("reset pin no clearing");
   a_release_clear:
      assert property ($fell(reset) |-> ##[0:2] clearing)
      else $error("no clearing after reset");
endmodule : dac_refresh_sequencer_props
bind dac_refresh_sequencer dac_refresh_sequencer_props props_i (
   .core_clk(core_clk), .reset(reset), .cs_n(cs_n),
   .reset_pin_n(reset_pin_n), .ext_clock_select_pin(ext_clock_select_pin),
   .conv(conv), .clearing(clearing), .ext_clock_active(ext_clock_active));

// file: dac_refresh_sequencer_tb.sv
`timescale 1ns/10ps
module dac_refresh_sequencer_tb;
   import dac_seq_pkg::*;
   logic core_clk = 0, reset = 0, reset_pin_n = 1, ext_run = 0;
   logic immediate_select_pin = 0, ext_clock_select_pin = 1, ext_seq_clock = 0;
   logic serial_clk, cs_n, serial_din, clearing, ext_clock_active;
   conv_s conv;
   logic [15:0] seen [16] = '{default: 16'h0000};
   logic [15:0] gap = 0;
   int cyc = 0, ld_cyc = 0, ediv = 0, failures = 0, num_checks = 0, t;
   always #12.5 core_clk = ~core_clk;
   dac_refresh_sequencer dac_refresh_sequencer_i (.core_clk(core_clk),
      .reset(reset), .serial_clk(serial_clk), .cs_n(cs_n),
      .serial_din(serial_din), .reset_pin_n(reset_pin_n),
      .immediate_select_pin(immediate_select_pin),
      .ext_clock_select_pin(ext_clock_select_pin),
      .ext_seq_clock(ext_seq_clock), .conv(conv), .clearing(clearing),
      .ext_clock_active(ext_clock_active));
   host_model host_model_i (.serial_clk(serial_clk), .cs_n(cs_n),
      .serial_din(serial_din));
   task automatic print_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task automatic chk(input string n, input logic [15:0] e, s);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
   endtask : settle
   task automatic wait_clear;
      for (t = 0; t < 14000 && clearing !== 1'h0; t++) @(posedge core_clk);
      chk("clear_end", 16'h0000, {15'h0000, clearing});
   endtask : wait_clear
   function automatic logic [23:0] mk(input logic [15:0] d,
      input logic [3:0] a, input logic u, c);
      return {d, a, 1'h0, u, c, 1'h0};
   endfunction : mk
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (conv.strobe) seen[conv.channel] <= conv.code;
      if (conv.load) begin
         gap <= 16'(cyc - ld_cyc);
         ld_cyc <= cyc;
      end
      if (ext_run && ediv == 4) ext_seq_clock <= ~ext_seq_clock;
      ediv <= (ediv == 4) ? 0 : ediv + 1;
      if (cyc == 90000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      reset <= 1'h1;
      settle(16);
      reset <= 1'h0;
      settle(400);
      chk("clr_ext", 16'h0000, {15'h0000, ext_clock_active});
      ext_clock_select_pin <= 1'h0;
      wait_clear;
      settle(800);
      for (int i = 0; i < 16; i++) chk("clr", 16'h4f2c, seen[i]);
      $display("clear done");
      host_model_i.frame({mk(16'h1234, 4'h3, 1'h0, 1'h0),
         mk(16'hbeef, 4'h9, 1'h0, 1'h0)}, 2);
      settle(26500);
      chk("burst3", 16'h1234, seen[3]);
      chk("burst9", 16'hbeef, seen[9]);
      $display("burst done");
      // bit source first, then pin source
      for (int k = 0; k < 2; k++) begin
         immediate_select_pin <= k[0];
         host_model_i.frame({mk(16'h5a5a + k[15:0], 4'hc - k[3:0], ~k[0],
            1'h0), 24'h00_0000}, 1);
         settle(1620);
         chk("immediate_select_pin", 16'h5a5a + k[15:0], seen[4'hc - k[3:0]]);
      end
      immediate_select_pin <= 1'h0;
      $display("immediate done");
      ext_run <= 1'h1;
      ext_clock_select_pin <= 1'h1;
      settle(10);
      chk("pin_ext", 16'h0001, {15'h0000, ext_clock_active});
      ext_clock_select_pin <= 1'h0;
      host_model_i.frame({mk(16'h0f0f, 4'h1, 1'h0, 1'h1), 24'h00_0000}, 1);
      settle(1200);
      chk("bit_ext", 16'h0001, {15'h0000, ext_clock_active});
      chk("ext_slot", 16'h0050, gap);
      ext_run <= 1'h0;
      settle(100);
      t = ld_cyc;
      settle(900);
      chk("halt", t[15:0], ld_cyc[15:0]);
      host_model_i.frame({mk(16'h0f0f, 4'h1, 1'h0, 1'h0), 24'h00_0000}, 1);
      settle(20);
      chk("int_clk", 16'h0000, {15'h0000, ext_clock_active});
      $display("external done");
      reset_pin_n <= 1'h0;
      settle(8);
      reset_pin_n <= 1'h1;
      settle(8);
      chk("pin_clr", 16'h0001, {15'h0000, clearing});
      host_model_i.frame({mk(16'hdead, 4'h3, 1'h1, 1'h0), 24'h00_0000}, 1);
      wait_clear;
      settle(13600);
      chk("ign3", 16'h4f2c, seen[3]);
      chk("clr9", 16'h4f2c, seen[9]);
      $display("reset pin done");
      print_verdict();
   end
endmodule : dac_refresh_sequencer_tb

// file: dac_seq_defs.svh
`ifndef DAC_SEQ_DEFS_SVH
`define DAC_SEQ_DEFS_SVH
// Function
// - scan all sixteen channels continuously when idle
// - load code, settle, then strobe channel
// - internal slot about 20 us, pass 320 us
// - external slot eight clocks, pass 128 clocks
// - immediate mode if pin or bit high
// - chip select fall stops scan, keeps address
// - slot in progress finishes undisturbed
// - immediate: store, refresh channel, resume scan
// - immediate update done within two slots
// - no refresh while chip select is low
// - immediate refresh only after select rises
// - burst mode only when pin and bit low
// - burst stores each word, outputs unchanged
// - burst resumes scan at interrupted address
// - all channels refreshed within 33 slots
// - external clocking runs at quarter clock rate
// - external clock if bit or pin high
// - select pin stops oscillator, clock may halt; slot_cnt_reg keeps counting on core_clk with the pin high
// - reset writes 4F2C to every channel
// - reset pin low starts same clearing
// - reset uses internal clock, ignores serial
// - 24-bit word msb first, fixed field order
`define SLOT_NS 20000
`define CLK_NS 25
`define SLOT_CYCLES ((`SLOT_NS + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_CYCLES 400
`define EXT_DIV 4
`define EXT_SLOT_TICKS 2
`define WORD_BITS 24
`define CLEAR_CODE 16'h4f2c
`define NUM_CH 16
`define F_DATA_HI 23
`define F_DATA_LO 8
`define F_ADDR_HI 7
`define F_ADDR_LO 4
`define F_UPD 2
`define F_CLK 1
`endif

// file: dac_seq_pkg.sv
package dac_seq_pkg;
   typedef struct packed {
      logic [15:0] data;
      logic [3:0] addr;
      logic upd;
      logic clk;
   } word_s;
   typedef struct packed {
      logic [15:0] code;
      logic [3:0] channel;
      logic load;
      logic strobe;
   } conv_s;
   typedef enum logic [1:0] {ST_CLEAR, ST_SCAN, ST_HOLD, ST_IMM} seq_e;
endpackage : dac_seq_pkg

// file: host_model.sv
`timescale 1ns/10ps
module host_model (
   output logic serial_clk,
   output logic cs_n,
   output logic serial_din
);
   initial begin
      serial_clk = 1'h0;
      cs_n = 1'h1;
      serial_din = 1'h0;
   end
   // link clock stands low between frames; words sent from bit 47 down
   task automatic frame(input logic [47:0] w, input int n);
      #3.3 cs_n = 1'h0;
      for (int i = 47; i >= 48 - 24 * n; i--) begin
         serial_din = w[i];
         #62.5 serial_clk = 1'h1;
         #62.5 serial_clk = 1'h0;
      end
      #62.5 cs_n = 1'h1;
      serial_din = ~serial_din; // undriven line, no pull
   endtask : frame
endmodule : host_model
